/* common/sbt_pkg.sv */
package sbt_pkg;

   // ******************************************************************
   // Register sizes and capture patterns
   // ******************************************************************
   localparam int IR_LEN = 3;
   localparam int ID_LEN = 32;
   localparam int BSR_LEN_X36 = 70;
   localparam int BSR_LEN_X18 = 51;
   localparam int SYNC_LEN = 2;
   localparam logic [1:0] IR_CAPT = 2'h1;
   localparam logic IR_CAPT_MSB = 1'h0;
   localparam logic BYP_CLEAR = 1'h0;

   // ******************************************************************
   // Instruction codes
   // ******************************************************************
   localparam logic [2:0] OP_EXTEST = 3'h0;
   localparam logic [2:0] OP_IDCODE_DEF = 3'h1;
   localparam logic [2:0] OP_SAMPLEZ_DEF = 3'h2;
   localparam logic [2:0] OP_SAMPLE_DEF = 3'h4;
   localparam logic [2:0] OP_BYPASS_DEF = 3'h7;

   // Arbitrary value, stands in for a maker code
   localparam logic [31:0] ID_VALUE_DEF = 32'h0000_0001;

   // ******************************************************************
   // Test-port states
   // ******************************************************************
   typedef enum logic [3:0] {
      ST_RESET  = 4'h0,
      ST_IDLE   = 4'h1,
      ST_SEL_DR = 4'h2,
      ST_CAP_DR = 4'h3,
      ST_SH_DR  = 4'h4,
      ST_EX1_DR = 4'h5,
      ST_PAU_DR = 4'h6,
      ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9,
      ST_CAP_IR = 4'hA,
      ST_SH_IR  = 4'hB,
      ST_EX1_IR = 4'hC,
      ST_PAU_IR = 4'hD,
      ST_EX2_IR = 4'hE,
      ST_UPD_IR = 4'hF
   } sbt_state_t;

   typedef enum logic [1:0] {
      DR_BYP = 2'h0,
      DR_ID  = 2'h1,
      DR_BSR = 2'h2
   } sbt_dr_sel_t;

endpackage

/* core/sbt_tap.sv */
// Summary of operation
// R01: Sample on test-clock rise, drive on fall
// R02: Mode-select sampled on rise steers machine
// R03: Data enters MSB, leaves from LSB
// R04: Output changes on fall, driven only shifting
// R05: Five high mode-select edges reset port
// R06: Power-up reset leaves output high-impedance
// R07: Current instruction picks one data register
// R08: Three-bit instruction, identify after reset
// R09: Capture-instruction loads 01 in low bits
// R10: One-bit bypass, cleared when bypass applies
// R11: Boundary register 70 or 51 bits
// R12: Capture-data snapshots ring, shift-data shifts it
// R13: Identify captures hardwired 32-bit value
// R14: Decode all eight codes, three reserved
// R15: New instruction only at update-instruction
// R16: All-zeros acts as sample plus float
// R17: Scanned data never drives memory pins
// R18: Sample-with-float shifts ring, floats outputs
// R19: Unused port keeps test clock low
// R20: Update-data under sample changes nothing
// R21: Bypass puts one bit between pins
// R22: Standard sixteen-state test-access sequence
// R23: Functional instruction codes are parameters
module sbt_tap #(
   parameter bit WIDE36 = 1'h1,
   parameter logic [31:0] ID_VALUE = sbt_pkg::ID_VALUE_DEF,
   parameter logic [2:0] OP_IDCODE = sbt_pkg::OP_IDCODE_DEF, // [R23]
   parameter logic [2:0] OP_SAMPLEZ = sbt_pkg::OP_SAMPLEZ_DEF, // [R23]
   parameter logic [2:0] OP_SAMPLE = sbt_pkg::OP_SAMPLE_DEF, // [R23]
   parameter logic [2:0] OP_BYPASS = sbt_pkg::OP_BYPASS_DEF, // [R23]
   localparam int BSR_LEN = WIDE36 ? sbt_pkg::BSR_LEN_X36
                                   : sbt_pkg::BSR_LEN_X18
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   input wire logic [BSR_LEN-1:0] io_ring_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   output logic mem_hiz_o
);
   import sbt_pkg::*;

   // ******************************************************************
   // State
   // ******************************************************************
   typedef struct packed {
      logic [SYNC_LEN:0] tck_sy;
      logic [SYNC_LEN-1:0] tms_sy;
      logic [SYNC_LEN-1:0] tdi_sy;
      logic [BSR_LEN-1:0] ring_m;
      logic [BSR_LEN-1:0] ring_s;
      sbt_state_t st;
      logic [IR_LEN-1:0] ir;
      logic [IR_LEN-1:0] ir_sh;
      logic byp;
      logic [ID_LEN-1:0] idr;
      logic [BSR_LEN-1:0] bsr;
      logic tdo;
      logic tdo_oe;
      logic hiz;
   } sbt_reg_t;

   sbt_reg_t r;
   sbt_reg_t next_r;
   sbt_state_t next_st;
   sbt_dr_sel_t sel;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   logic shifting;
   logic lsb;

   // Second stages, plus the third for the test clock; the first stages feed nothing else
   assign tck_rise = r.tck_sy[1] & ~r.tck_sy[2]; // [R01]
   assign tck_fall = ~r.tck_sy[1] & r.tck_sy[2]; // [R01]
   assign tms = r.tms_sy[1]; // [R02]
   assign tdi = r.tdi_sy[1];

   // ******************************************************************
   // Instruction decode
   // ******************************************************************
   // Reserved codes fall back to bypass so a stray load stays harmless
   always_comb
   begin
      if (r.ir == OP_IDCODE)
         sel = DR_ID; // [R07] [R14]
      else if (r.ir == OP_EXTEST || r.ir == OP_SAMPLE ||
               r.ir == OP_SAMPLEZ)
         sel = DR_BSR; // [R16] [R18]
      else
         sel = DR_BYP; // [R14] [R21]
   end

   // ******************************************************************
   // Test-access state sequence
   // ******************************************************************
   always_comb
   begin
      unique case (r.st) // [R22] [R05]
         ST_RESET:  next_st = tms ? ST_RESET : ST_IDLE;
         ST_IDLE:   next_st = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_st = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_st = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_st = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_st = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: next_st = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: next_st = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_st = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_st = tms ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: next_st = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_st = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_st = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: next_st = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: next_st = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_st = tms ? ST_SEL_DR : ST_IDLE;
      endcase
   end

   assign shifting = (r.st == ST_SH_DR) || (r.st == ST_SH_IR);

   always_comb
   begin
      if (r.st == ST_SH_IR)
         lsb = r.ir_sh[0]; // [R03]
      else if (sel == DR_ID)
         lsb = r.idr[0];
      else if (sel == DR_BSR)
         lsb = r.bsr[0];
      else
         lsb = r.byp;
   end

   // ******************************************************************
   // Register updates
   // ******************************************************************
   always_comb
   begin
      next_r = r;
      next_r.tck_sy = {r.tck_sy[SYNC_LEN-1:0], tck_i};
      next_r.tms_sy = {r.tms_sy[0], tms_i};
      next_r.tdi_sy = {r.tdi_sy[0], tdi_i};
      // Ring runs on the memory clock; a value caught mid-change is
      // simply unreliable, never harmful
      next_r.ring_m = io_ring_i;
      next_r.ring_s = r.ring_m;
      if (tck_rise)
      begin
         next_r.st = next_st; // [R02]
         if (r.st == ST_RESET)
            next_r.ir = OP_IDCODE; // [R08]
         else if (r.st == ST_CAP_IR)
            next_r.ir_sh = {IR_CAPT_MSB, IR_CAPT}; // [R09]
         else if (r.st == ST_SH_IR)
            next_r.ir_sh = {tdi, r.ir_sh[IR_LEN-1:1]}; // [R03]
         else if (r.st == ST_UPD_IR)
         begin
            next_r.ir = r.ir_sh; // [R15]
            if (r.ir_sh == OP_BYPASS)
               next_r.byp = BYP_CLEAR; // [R10]
         end
         else if (r.st == ST_CAP_DR)
         begin
            if (sel == DR_ID)
               next_r.idr = ID_VALUE; // [R13]
            else if (sel == DR_BSR)
               next_r.bsr = r.ring_s; // [R12] [R17]
            else
               next_r.byp = BYP_CLEAR; // [R10]
         end
         else if (r.st == ST_SH_DR)
         begin
            if (sel == DR_ID)
               next_r.idr = {tdi, r.idr[ID_LEN-1:1]}; // [R03] [R13]
            else if (sel == DR_BSR)
               next_r.bsr = {tdi, r.bsr[BSR_LEN-1:1]}; // [R11] [R12]
            else
               next_r.byp = tdi; // [R21]
         end
         // Update-data holds everything: no preload path exists [R20]
      end
      if (tck_fall)
      begin
         next_r.tdo_oe = shifting; // [R04]
         next_r.tdo = shifting ? lsb : 1'h0; // [R04] [R01]
      end
      // Float only; the boundary cells never reach the pads [R17]
      next_r.hiz = (next_r.ir == OP_EXTEST) ||
                   (next_r.ir == OP_SAMPLEZ); // [R16] [R18]
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r <= '0;
         r.st <= ST_RESET; // [R06]
         r.ir <= OP_IDCODE; // [R08]
      end
      else
         r <= next_r;
   end

   assign tdo_o = r.tdo;
   assign tdo_oe_o = r.tdo_oe;
   assign mem_hiz_o = r.hiz;

   // ******************************************************************
   // Checks
   // ******************************************************************
   logic [2:0] hi_cnt;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         hi_cnt <= 3'h0;
      else if (tck_rise)
         hi_cnt <= !tms ? 3'h0 : (hi_cnt == 3'h5 ? 3'h5 : hi_cnt + 3'h1);
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_reset_state;
      disable iff (1'b0)
      rst_i |=> (r.st == ST_RESET && r.ir == OP_IDCODE && !tdo_oe_o);
   endproperty
   a_reset_state: assert property (p_reset_state) // [R06] [R08]
      else $error("reset did not idle the port");

   property p_five_high;
      tck_rise && tms && hi_cnt == 3'h4 |=> r.st == ST_RESET;
   endproperty
   a_five_high: assert property (p_five_high) // [R05]
      else $error("five high mode edges did not reset");

   property p_tdo_enable;
      tck_fall |=> tdo_oe_o == $past(shifting);
   endproperty
   a_tdo_enable: assert property (p_tdo_enable) // [R04]
      else $error("serial output enable wrong after fall");

   property p_tdo_hold;
      !tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_o);
   endproperty
   a_tdo_hold: assert property (p_tdo_hold) // [R01]
      else $error("serial output moved off a falling edge");

   property p_cap_ir;
      tck_rise && r.st == ST_CAP_IR |=> r.ir_sh[1:0] == IR_CAPT;
   endproperty
   a_cap_ir: assert property (p_cap_ir) // [R09]
      else $error("capture pattern not loaded");

   property p_ir_change;
      $changed(r.ir) |-> $past(r.st) == ST_UPD_IR ||
                         $past(r.st) == ST_RESET;
   endproperty
   a_ir_change: assert property (p_ir_change) // [R15]
      else $error("instruction changed outside update");

   property p_cap_id;
      tck_rise && r.st == ST_CAP_DR && r.ir == OP_IDCODE
         |=> r.idr == ID_VALUE;
   endproperty
   a_cap_id: assert property (p_cap_id) // [R13]
      else $error("identification value not captured");

   property p_cap_bsr;
      tck_rise && r.st == ST_CAP_DR && sel == DR_BSR
         |=> r.bsr == $past(r.ring_s);
   endproperty
   a_cap_bsr: assert property (p_cap_bsr) // [R12]
      else $error("ring snapshot not captured");

   property p_shift_msb;
      tck_rise && r.st == ST_SH_DR && sel == DR_BSR
         |=> r.bsr[BSR_LEN-1] == $past(tdi);
   endproperty
   a_shift_msb: assert property (p_shift_msb) // [R03]
      else $error("serial input missed the top bit");

   property p_bypass;
      tck_rise && r.st == ST_SH_DR && sel == DR_BYP
         |=> r.byp == $past(tdi) && $stable(r.bsr) && $stable(r.idr);
   endproperty
   a_bypass: assert property (p_bypass) // [R21] [R07]
      else $error("bypass shift wrong");

   property p_upd_dr;
      tck_rise && r.st == ST_UPD_DR |=> $stable(r.bsr);
   endproperty
   a_upd_dr: assert property (p_upd_dr) // [R20]
      else $error("update-data touched boundary cells");

   property p_float;
      mem_hiz_o == (r.ir == OP_EXTEST || r.ir == OP_SAMPLEZ);
   endproperty
   a_float: assert property (p_float) // [R16] [R18]
      else $error("float output disagrees with instruction");

   c_id_shift: cover property (tck_rise && r.st == ST_SH_DR &&
                               sel == DR_ID);
   c_bsr_shift: cover property (tck_rise && r.st == ST_SH_DR &&
                                sel == DR_BSR);
   c_float: cover property (mem_hiz_o && r.st == ST_SH_DR);
   c_five: cover property (hi_cnt == 3'h5);

endmodule

/* test/sbt_ctl_model.sv */
// ******************************************************************
// Scan controller on the far side of the test port
// ******************************************************************
module sbt_ctl_model (
   input wire logic clk_i,
   input wire logic tdo_i,
   input wire logic tdo_oe_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_tdo;
   logic wire_tdo;
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      last_tdo = 1'b0;
   end
   always @(posedge clk_i)
      if (tdo_oe_i)
         last_tdo <= tdo_i;
   // A released line must not keep showing its last bit
   assign wire_tdo = tdo_oe_i ? tdo_i : ~last_tdo;
   // One 320 ns test-clock cycle; the clock rests low between calls
   task automatic step(input logic tms, input logic tdi,
                       output logic tdo, output logic oe);
      @(posedge clk_i);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (4) @(posedge clk_i);
      tdo = wire_tdo;
      oe = tdo_oe_i;
      tck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      tck_o <= 1'b0;
   endtask
endmodule

/* test/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbt_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [69:0] ring = 70'h2A_5A5A_C3C3_0F0F_1234;
   logic tck, tms, tdi, tdo, tdo_oe, mem_hiz;
   logic hiz_exp = 1'b0;
   int error_cnt = 0;
   int comparisons = 0;

   always #20 clk_i = ~clk_i;

   sbt_tap sbt_tap_i (
      .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .io_ring_i(ring), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .mem_hiz_o(mem_hiz));
   sbt_ctl_model ctl_i (
      .clk_i(clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
      .tms_o(tms), .tdi_o(tdi));

   // ******************************************************************
   // Shared tasks
   // ******************************************************************
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic go(input logic t);
      logic d, e;
      ctl_i.step(t, 1'b1, d, e);
   endtask

   // Leaves through Exit1 on the last bit
   task automatic shift(input int n, input logic [79:0] din,
                        output logic [79:0] dout);
      logic d, e;
      dout = '0;
      for (int i = 0; i < n; i++)
      begin
         ctl_i.step(i == n - 1, din[i], d, e);
         dout[i] = d;
         check(e, 1'b1);
      end
   endtask

   task automatic scan_dr(input int n, input logic [79:0] din,
                          output logic [79:0] dout);
      logic d, e;
      go(1'b1);
      go(1'b0);
      go(1'b0);
      shift(n, din, dout);
      go(1'b1);
      ctl_i.step(1'b0, 1'b1, d, e);
      check(e, 1'b0);
   endtask

   task automatic load_ir(input logic [2:0] code, input logic hiz);
      logic [79:0] o;
      go(1'b1);
      go(1'b1);
      go(1'b0);
      go(1'b0);
      shift(3, {77'h0, code}, o);
      check(o[2:0], 3'h1);
      check(mem_hiz, hiz_exp);
      go(1'b1);
      go(1'b0);
      // Float flag is registered in the same clock as the held instruction
      repeat (4) @(posedge clk_i);
      check(mem_hiz, hiz);
      hiz_exp = hiz;
   endtask

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic t_reset_id();
      logic [79:0] o;
      check(tdo_oe, 1'b0);
      go(1'b0);
      scan_dr(34, 80'h2, o);
      check(o[33:0], {2'h2, ID_VALUE_DEF});
      $display("test reset_id done");
   endtask

   task automatic t_bypass();
      logic [79:0] o;
      load_ir(OP_BYPASS_DEF, 1'b0);
      scan_dr(8, 80'hA5, o);
      check(o[7:0], 8'h4A);
      $display("test bypass done");
   endtask

   task automatic t_samplez();
      logic [79:0] o;
      load_ir(OP_SAMPLEZ_DEF, 1'b1);
      scan_dr(72, 80'h3, o);
      check(o[71:0], {2'h3, ring});
      $display("test samplez done");
   endtask

   task automatic t_extest();
      logic [79:0] o;
      @(posedge clk_i);
      ring <= ~ring;
      load_ir(OP_EXTEST, 1'b1);
      scan_dr(72, 80'h1, o);
      check(o[71:0], {2'h1, ring});
      $display("test extest done");
   endtask

   task automatic t_tap_reset();
      logic [79:0] o;
      load_ir(OP_BYPASS_DEF, 1'b0);
      repeat (5) go(1'b1);
      go(1'b0);
      scan_dr(34, 80'h0, o);
      check(o[33:0], {2'h0, ID_VALUE_DEF});
      $display("test tap_reset done");
   endtask

   task automatic t_sample();
      logic [79:0] o;
      load_ir(OP_SAMPLE_DEF, 1'b0);
      scan_dr(72, 80'hFFFF_FFFF_FFFF_FFFF_FFFF, o);
      check(o[71:0], {2'h3, ring});
      check(mem_hiz, 1'b0);
      scan_dr(72, 80'h0, o);
      check(o[71:0], {2'h0, ring});
      $display("test sample done");
   endtask

   task automatic t_reserved();
      logic [79:0] o;
      logic [2:0] codes [3] = '{3'h3, 3'h5, 3'h6};
      foreach (codes[i])
      begin
         load_ir(codes[i], 1'b0);
         scan_dr(2, 80'h3, o);
         check(o[1:0], 2'h2);
      end
      $display("test reserved done");
   endtask

   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_reset_id();
      t_bypass();
      t_samplez();
      t_extest();
      t_tap_reset();
      t_sample();
      t_reserved();
      tally_and_finish();
   end

   initial
   begin
      repeat (40000) @(posedge clk_i);
      error_cnt++;
      tally_and_finish();
   end
endmodule
